/* inc/timer_pkg.sv */
// constants and types shared by the dual channel down timer
package timer_pkg;

   localparam int unsigned ADDR_WIDTH = 12;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned PRESCALE_WIDTH = 8;

   // register byte offsets from timer_base_address
   localparam logic [11:0] OFF_CHANNEL0_CONTROL_STATUS = 12'h000;
   localparam logic [11:0] OFF_CHANNEL1_CONTROL_STATUS = 12'h004;
   localparam logic [11:0] OFF_CHANNEL0_RELOAD_COUNT   = 12'h008;
   localparam logic [11:0] OFF_CHANNEL1_RELOAD_COUNT   = 12'h00c;
   localparam logic [11:0] OFF_CHANNEL0_CURRENT_COUNT  = 12'h010;
   localparam logic [11:0] OFF_CHANNEL1_CURRENT_COUNT  = 12'h014;
   localparam logic [11:0] OFF_INTERRUPT_FLAG_REGISTER = 12'h018;

   // control/status field positions
   localparam int unsigned BIT_DEBUG_HOLD_OVERRIDE = 31;
   localparam int unsigned BIT_COUNTER_ENABLE      = 30;
   localparam int unsigned BIT_INTERRUPT_ENABLE    = 29;
   localparam int unsigned BIT_MODE_HI             = 28;
   localparam int unsigned BIT_MODE_LO             = 27;
   localparam int unsigned BIT_COUNTER_CLEAR       = 26;
   localparam int unsigned BIT_COUNTER_ACTIVE      = 25;
   localparam int unsigned BIT_PRESCALE_HI         = 7;
   localparam int unsigned BIT_PRESCALE_LO         = 0;

   // values after reset
   localparam logic [31:0] CONTROL_STATUS_RESET = 32'h0000_0005;
   localparam logic [7:0]  PRESCALE_RESET       = 8'h05;
   localparam logic [31:0] RELOAD_COUNT_RESET   = 32'h0000_0000;
   localparam logic [31:0] CURRENT_COUNT_RESET  = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_ONE_SHOT      = 2'b00,
      MODE_PERIODIC      = 2'b01,
      MODE_TOGGLE        = 2'b10,
      MODE_UNINTERRUPTED = 2'b11
   } mode_t;

endpackage : timer_pkg

/* logic/prescale_divider.sv */
// prescale divider: turns timer input clock edges into count steps
`timescale 1ns/10ps
`default_nettype none

module prescale_divider
   import timer_pkg::*;
#(
   parameter int unsigned WIDTH = PRESCALE_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             timer_input_clock_i,
   input  wire logic             run_i,
   input  wire logic             clear_i,
   input  wire logic [WIDTH-1:0] divisor_i,
   output logic                  step_o
);

   if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
      $error("prescale_divider: WIDTH must be 1 to 16");
   end

   typedef struct packed {
      logic             timer_input_clock_prev;
      logic [WIDTH-1:0] pcnt;
   } div_state_t;

   div_state_t s;
   div_state_t next_s;
   logic       edge_seen;

   always_comb begin
      next_s = s;
      step_o = 1'b0;
      edge_seen = timer_input_clock_i & ~s.timer_input_clock_prev;
      next_s.timer_input_clock_prev = timer_input_clock_i;
      if (clear_i) begin
         next_s.pcnt = '0;
      end else if (run_i && edge_seen) begin
         // divide by divisor+1; zero passes every edge
         // a prescale lowered mid-count ends the cycle instead of wrapping
         if (s.pcnt >= divisor_i) begin
            next_s.pcnt = '0;
            step_o = 1'b1;
         end else begin
            next_s.pcnt = s.pcnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : prescale_divider

`default_nettype wire

/* logic/dual_channel_down_timer.sv */
// two-channel prescaled 32-bit down timer with an APB register slave
`timescale 1ns/10ps
`default_nettype none

module dual_channel_down_timer
   import timer_pkg::*;
#(
   parameter int unsigned CHANNELS = 2
) (
   input  wire logic                  CLK_I,
   input  wire logic                  NRST_I,
   // APB slave
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [ADDR_WIDTH-1:0] PADDR_I,
   input  wire logic [DATA_WIDTH-1:0] PWDATA_I,
   output logic       [DATA_WIDTH-1:0] PRDATA_O,
   output logic                        PREADY_O,
   output logic                        PSLVERR_O,
   // timer side
   input  wire logic                  TIMER_INPUT_CLOCK0_I,
   input  wire logic                  TIMER_INPUT_CLOCK1_I,
   input  wire logic                  DEBUG_ACKNOWLEDGE_INPUT_I,
   output logic                        IRQ0_O,
   output logic                        IRQ1_O,
   output logic                        TOGGLE0_O,
   output logic                        TOGGLE1_O
);

   if (CHANNELS != 2) begin : g_channels_check
      $error("dual_channel_down_timer: register map serves two channels");
   end

   // the field layout assumes these package widths; an edit to them
   // would push fields out of the word without any other warning
   if (DATA_WIDTH != 32) begin : g_data_width_check
      $error("dual_channel_down_timer: data path must be 32 bits");
   end
   if (ADDR_WIDTH != 12) begin : g_addr_width_check
      $error("dual_channel_down_timer: offsets must be 12 bits");
   end
   if (PRESCALE_WIDTH != BIT_PRESCALE_HI + 1) begin : g_prescale_check
      $error("dual_channel_down_timer: prescale width must match field");
   end

   typedef struct packed {
      logic                      debug_hold_override;
      logic                      counter_enable;
      logic                      interrupt_enable;
      logic [1:0]                mode;
      logic [PRESCALE_WIDTH-1:0] prescale;
      logic [DATA_WIDTH-1:0]     initial_count;
      logic [DATA_WIDTH-1:0]     current_count;
      logic                      expiry_flag;
      logic                      toggle;
   } chan_t;

   typedef struct packed {
      chan_t [1:0]           ch;
      logic [DATA_WIDTH-1:0] rdata;
      logic                  ready;
      logic                  slverr;
   } state_t;

   state_t s;
   state_t next_s;

   logic [1:0] timer_input_clock;
   logic [1:0] run;
   logic [1:0] step;
   logic [1:0] div_clear;
   logic [1:0] wr_ctrl;
   logic [1:0] wr_reload;
   logic       wr_flags;
   logic       setup;
   logic       access_wr;

   assign timer_input_clock = {TIMER_INPUT_CLOCK1_I, TIMER_INPUT_CLOCK0_I};

   // decode of a byte offset; used for both reads and writes
   function automatic logic addr_mapped(input logic [ADDR_WIDTH-1:0] a);
      case (a)
         OFF_CHANNEL0_CONTROL_STATUS,
         OFF_CHANNEL1_CONTROL_STATUS,
         OFF_CHANNEL0_RELOAD_COUNT,
         OFF_CHANNEL1_RELOAD_COUNT,
         OFF_CHANNEL0_CURRENT_COUNT,
         OFF_CHANNEL1_CURRENT_COUNT,
         OFF_INTERRUPT_FLAG_REGISTER: addr_mapped = 1'b1;
         default:                     addr_mapped = 1'b0;
      endcase
   endfunction : addr_mapped

   // write strobe of one register offset
   function automatic logic wr_hit(input logic                  strobe,
                                   input logic [ADDR_WIDTH-1:0] a,
                                   input logic [ADDR_WIDTH-1:0] off);
      wr_hit = strobe && a == off;
   endfunction : wr_hit

   // counter runs when enabled and not frozen by the debugger
   function automatic logic chan_running(input chan_t c, input logic dbg);
      chan_running = c.counter_enable
                     & ~(dbg & ~c.debug_hold_override);
   endfunction : chan_running

   // control/status word; clear bit self-clears, reserved bits are zero
   function automatic logic [DATA_WIDTH-1:0] ctrl_word(input chan_t c,
                                                     input logic active);
      logic [DATA_WIDTH-1:0] w;
      w = '0;
      w[BIT_DEBUG_HOLD_OVERRIDE]         = c.debug_hold_override;
      w[BIT_COUNTER_ENABLE]              = c.counter_enable;
      w[BIT_INTERRUPT_ENABLE]            = c.interrupt_enable;
      w[BIT_MODE_HI:BIT_MODE_LO]         = c.mode;
      w[BIT_COUNTER_ACTIVE]              = active;
      w[BIT_PRESCALE_HI:BIT_PRESCALE_LO] = c.prescale;
      ctrl_word = w;
   endfunction : ctrl_word

   function automatic logic [DATA_WIDTH-1:0] read_word(
         input logic [ADDR_WIDTH-1:0] a, input state_t st,
         input logic [1:0] act);
      case (a)
         OFF_CHANNEL0_CONTROL_STATUS: read_word = ctrl_word(st.ch[0], act[0]);
         OFF_CHANNEL1_CONTROL_STATUS: read_word = ctrl_word(st.ch[1], act[1]);
         OFF_CHANNEL0_RELOAD_COUNT:   read_word = st.ch[0].initial_count;
         OFF_CHANNEL1_RELOAD_COUNT:   read_word = st.ch[1].initial_count;
         // live count; only stable while the channel is disabled or frozen by the debugger
         OFF_CHANNEL0_CURRENT_COUNT:
            read_word = st.ch[0].current_count;
         OFF_CHANNEL1_CURRENT_COUNT:
            read_word = st.ch[1].current_count;
         OFF_INTERRUPT_FLAG_REGISTER: read_word = {{(DATA_WIDTH-2){1'b0}},
                                                  st.ch[1].expiry_flag,
                                                  st.ch[0].expiry_flag};
         default:                     read_word = '0;
      endcase
   endfunction : read_word

   // apb phases: data is captured in setup so every access has no wait
   assign setup     = PSEL_I & ~PENABLE_I;
   assign access_wr = PSEL_I & PENABLE_I & PWRITE_I & s.ready
                      & addr_mapped(PADDR_I);
   assign wr_flags  = wr_hit(access_wr, PADDR_I,
                             OFF_INTERRUPT_FLAG_REGISTER);

   always_comb begin
      wr_ctrl[0]   = wr_hit(access_wr, PADDR_I, OFF_CHANNEL0_CONTROL_STATUS);
      wr_ctrl[1]   = wr_hit(access_wr, PADDR_I, OFF_CHANNEL1_CONTROL_STATUS);
      wr_reload[0] = wr_hit(access_wr, PADDR_I, OFF_CHANNEL0_RELOAD_COUNT);
      wr_reload[1] = wr_hit(access_wr, PADDR_I, OFF_CHANNEL1_RELOAD_COUNT);
      for (int c = 0; c < 2; c++) begin
         run[c] = chan_running(s.ch[c], DEBUG_ACKNOWLEDGE_INPUT_I);
         // prescaler restarts on counter clear or new initial count
         div_clear[c] = (wr_ctrl[c] & PWDATA_I[BIT_COUNTER_CLEAR])
                        | wr_reload[c];
      end
   end

   // one prescaler per channel, each on its own input clock
   for (genvar g = 0; g < 2; g++) begin : g_div
      prescale_divider #(
         .WIDTH     (PRESCALE_WIDTH)
      ) u_div (
         .clk_i     (CLK_I),
         .nrst_i    (NRST_I),
         .timer_input_clock_i    (timer_input_clock[g]),
         .run_i     (run[g]),
         .clear_i   (div_clear[g]),
         .divisor_i (s.ch[g].prescale),
         .step_o    (step[g])
      );
   end

   always_comb begin
      logic expire;
      logic flag_set;
      logic flag_clr;
      expire = 1'b0;
      flag_set = 1'b0;
      flag_clr = 1'b0;
      next_s = s;

      for (int c = 0; c < 2; c++) begin
         expire = 1'b0;
         // count step from the prescaler
         if (step[c]) begin
            if (s.ch[c].current_count == '0) begin
               // first step after clear picks up the initial count
               next_s.ch[c].current_count = s.ch[c].initial_count;
            end else if (s.ch[c].current_count == 32'h0000_0001) begin
               next_s.ch[c].current_count =
                  s.ch[c].initial_count;
               expire = 1'b1;
            end else begin
               next_s.ch[c].current_count = s.ch[c].current_count - 1'b1;
            end
         end

         // every mode signals on expiry; uninterrupted mode fires as the
         // count is reloaded, i.e. on the step from 1 back to the initial count
         flag_set = expire
                    & s.ch[c].interrupt_enable;
         if (expire) begin
            case (mode_t'(s.ch[c].mode))
               MODE_ONE_SHOT:
                  next_s.ch[c].counter_enable = 1'b0;
               MODE_PERIODIC:
                  next_s.ch[c].toggle = s.ch[c].toggle;
               MODE_TOGGLE:
                  next_s.ch[c].toggle = ~s.ch[c].toggle;
               MODE_UNINTERRUPTED:
                  next_s.ch[c].toggle = s.ch[c].toggle;
               default:
                  next_s.ch[c].toggle = s.ch[c].toggle;
            endcase
         end

         // software write of control; last write beats hardware clear
         if (wr_ctrl[c]) begin
            next_s.ch[c].debug_hold_override =
               PWDATA_I[BIT_DEBUG_HOLD_OVERRIDE];
            next_s.ch[c].counter_enable      = PWDATA_I[BIT_COUNTER_ENABLE];
            next_s.ch[c].interrupt_enable    = PWDATA_I[BIT_INTERRUPT_ENABLE];
            next_s.ch[c].mode     = PWDATA_I[BIT_MODE_HI:BIT_MODE_LO];
            next_s.ch[c].prescale = PWDATA_I[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
            if (PWDATA_I[BIT_COUNTER_CLEAR]) begin
               next_s.ch[c].current_count  = '0;
               next_s.ch[c].counter_enable = 1'b0;
               next_s.ch[c].toggle         = 1'b0;
            end
         end

         // new initial count aborts the run regardless of enable;
         // a zero here leaves the counter idle at zero
         if (wr_reload[c]) begin
            next_s.ch[c].initial_count = PWDATA_I;
            next_s.ch[c].current_count = PWDATA_I;
         end

         // sticky flag: a set in the clearing cycle survives
         flag_clr = wr_flags & PWDATA_I[c];
         next_s.ch[c].expiry_flag = (s.ch[c].expiry_flag & ~flag_clr)
                                    | flag_set;
      end

      // apb response, registered so every bus output is a flop
      next_s.ready  = setup & ~s.ready;
      next_s.slverr = setup & ~s.ready & ~addr_mapped(PADDR_I);
      if (setup && !PWRITE_I) begin
         next_s.rdata = read_word(PADDR_I, s, run);
      end else if (!PSEL_I) begin
         next_s.rdata = '0;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s <= '0;
         for (int c = 0; c < 2; c++) begin
            s.ch[c].prescale      <= PRESCALE_RESET;
            s.ch[c].initial_count <= RELOAD_COUNT_RESET;
            s.ch[c].current_count <= CURRENT_COUNT_RESET;
         end
      end else begin
         s <= next_s;
      end
   end

   assign PRDATA_O  = s.rdata;
   assign PREADY_O  = s.ready;
   assign PSLVERR_O = s.slverr;
   assign IRQ0_O    = s.ch[0].expiry_flag;
   assign IRQ1_O    = s.ch[1].expiry_flag;
   assign TOGGLE0_O = s.ch[0].toggle;
   assign TOGGLE1_O = s.ch[1].toggle;

endmodule : dual_channel_down_timer

`default_nettype wire

/* verif/dual_channel_down_timer_assertions.sv */
// bus and timer output checks bound to the timer top
`timescale 1ns/10ps
`default_nettype none
module timer_checker (
   input wire logic        CLK_I,
   input wire logic        NRST_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        TIMER_INPUT_CLOCK0_I,
   input wire logic        TIMER_INPUT_CLOCK1_I,
   input wire logic        IRQ0_O,
   input wire logic        TOGGLE0_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!NRST_I);
   logic clr0;
   logic bad;
   assign clr0 = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O
                 && PADDR_I == 12'h018 && PWDATA_I[0];
   assign bad = !(PADDR_I inside {12'h000, 12'h004, 12'h008, 12'h00c,
                                  12'h010, 12'h014, 12'h018});
   sequence setup_s;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence odd_s;
      setup_s ##0 bad;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> PREADY_O)
      else $error("no ready after setup");
   ready_one_cycle_a: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready held too long");
   unmapped_error_a: assert property (odd_s |=> PSLVERR_O)
      else $error("unmapped access without error");
   unmapped_zero_a: assert property (odd_s ##0 !PWRITE_I |=> PRDATA_O == 0)
      else $error("unmapped read not zero");
   mapped_ok_a: assert property (setup_s ##0 !bad |=> !PSLVERR_O)
      else $error("mapped access flagged as error");
   flag_sticky_a: assert property (IRQ0_O && !clr0 |=> IRQ0_O)
      else $error("expiry flag dropped without clear");
   toggle_from_tick_a: assert property ($rose(TOGGLE0_O) |->
      $past(TIMER_INPUT_CLOCK0_I) || $past(TIMER_INPUT_CLOCK0_I, 2))
      else $error("toggle rose without input tick");
   flag_set_by_tick_a: assert property ($rose(IRQ0_O) |->
      $past(TIMER_INPUT_CLOCK0_I) || $past(TIMER_INPUT_CLOCK0_I, 2))
      else $error("flag rose without input tick");
endmodule : timer_checker
bind dual_channel_down_timer timer_checker timer_checker_inst (
   .CLK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
   .PRDATA_O, .PREADY_O, .PSLVERR_O, .TIMER_INPUT_CLOCK0_I,
   .TIMER_INPUT_CLOCK1_I, .IRQ0_O, .TOGGLE0_O);
`default_nettype wire

/* verif/apb_host.sv */
// register bus host model standing in for processor software
`timescale 1ns/10ps
`default_nettype none
module apb_host (
   input  wire logic        clk_i,
   input  wire logic        ready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic        err_i,
   output logic             sel_o,
   output logic             en_o,
   output logic             wr_o,
   output logic [11:0]      addr_o,
   output logic [31:0]      wdata_o
);
   initial begin
      sel_o = 1'b0;
      en_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 12'h0;
      wdata_o = 32'h0;
   end
   // zero initial counts are never written by callers
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_i);
      #1;
      sel_o = 1'b1;
      wr_o = w;
      addr_o = a;
      wdata_o = d;
      @(posedge clk_i);
      #1;
      en_o = 1'b1;
      n = 0;
      @(posedge clk_i);
      while (ready_i !== 1'b1 && n < 8) begin
         n++;
         @(posedge clk_i);
      end
      q = rdata_i;
      // a transfer that never saw ready reports an unknown error bit
      e = (ready_i === 1'b1) ? err_i : 1'bx;
      #1;
      sel_o = 1'b0;
      en_o = 1'b0;
      // released lines must not keep showing the last value
      addr_o = ~a;
      wdata_o = ~d;
   endtask : xfer
endmodule : apb_host
`default_nettype wire

/* verif/dual_channel_down_timer_tb.sv */
// self-checking bench for the dual channel down timer
`timescale 1ns/10ps
`default_nettype none
module dual_channel_down_timer_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel, pen, pwr, pready, perr, dbg = 1'b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  tck = 2'b00;
   logic        irq0, irq1, tog0, tog1;
   int          fails = 0;
   int          num_checks = 0;
   always #5 clk = ~clk;
   dual_channel_down_timer dual_channel_down_timer_inst (
      .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
      .TIMER_INPUT_CLOCK0_I(tck[0]), .TIMER_INPUT_CLOCK1_I(tck[1]),
      .DEBUG_ACKNOWLEDGE_INPUT_I(dbg), .IRQ0_O(irq0), .IRQ1_O(irq1),
      .TOGGLE0_O(tog0), .TOGGLE1_O(tog1));
   apb_host apb_host_inst (
      .clk_i(clk), .ready_i(pready), .rdata_i(prdata), .err_i(perr),
      .sel_o(psel), .en_o(pen), .wr_o(pwr), .addr_o(paddr),
      .wdata_o(pwdata));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb_host_inst.xfer(1'b1, a, d, q, e);
      chk("bus error", 32'(e), 32'h0);
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb_host_inst.xfer(1'b0, a, 32'h0, q, e);
      chk($sformatf("reg %h", a), q, exp);
      chk("bus error", 32'(e), 32'(a == 12'h020));
   endtask : rc
   // one input clock period: high two cycles, low three for the output
   task automatic tick(input int c, input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         tck[c] = 1'b1;
         repeat (2) @(posedge clk);
         #1;
         tck[c] = 1'b0;
         repeat (3) @(posedge clk);
         #1;
      end
   endtask : tick
   task automatic s_reset;
      rc(12'h000, 32'h0000_0005);
      rc(12'h004, 32'h0000_0005);
      rc(12'h008, 32'h0);
      rc(12'h00c, 32'h0);
      rc(12'h020, 32'h0);
   endtask : s_reset
   task automatic s_periodic;
      wr(12'h008, 32'h2);
      wr(12'h000, 32'h6800_0000);
      tick(0, 1);
      chk("irq0", 32'(irq0), 32'h0);
      tick(0, 1);
      chk("irq0", 32'(irq0), 32'h1);
      rc(12'h000, 32'h6a00_0000);
      wr(12'h018, 32'h1);
      chk("irq0", 32'(irq0), 32'h0);
      tick(0, 2);
      chk("irq0", 32'(irq0), 32'h1);
      wr(12'h018, 32'h1);
   endtask : s_periodic
   task automatic s_stop;
      wr(12'h000, 32'h0);
      wr(12'h008, 32'h7);
      rc(12'h010, 32'h7);
      tick(0, 2);
      rc(12'h010, 32'h7);
   endtask : s_stop
   task automatic s_toggle;
      wr(12'h008, 32'h1);
      wr(12'h000, 32'h5000_0001);
      tick(0, 1);
      chk("toggle0", 32'(tog0), 32'h0);
      tick(0, 1);
      chk("toggle0", 32'(tog0), 32'h1);
      tick(0, 2);
      chk("toggle0", 32'(tog0), 32'h0);
      tick(0, 2);
      chk("toggle0", 32'(tog0), 32'h1);
      chk("irq0", 32'(irq0), 32'h0);
      wr(12'h000, 32'h0400_0000);
      chk("toggle0", 32'(tog0), 32'h0);
      rc(12'h000, 32'h0);
      rc(12'h010, 32'h0);
   endtask : s_toggle
   task automatic s_debug;
      dbg = 1'b1;
      wr(12'h008, 32'h3);
      wr(12'h000, 32'h4800_0000);
      tick(0, 2);
      rc(12'h010, 32'h3);
      rc(12'h000, 32'h4800_0000);
      wr(12'h000, 32'hc800_0000);
      tick(0, 1);
      rc(12'h010, 32'h2);
      dbg = 1'b0;
   endtask : s_debug
   task automatic s_ch1;
      wr(12'h00c, 32'h1);
      wr(12'h004, 32'h6000_0000);
      tick(1, 1);
      chk("irq1", 32'(irq1), 32'h1);
      rc(12'h004, 32'h2000_0000);
      wr(12'h018, 32'h2);
      wr(12'h00c, 32'h2);
      wr(12'h004, 32'h78ff_ff00);
      rc(12'h004, 32'h7a00_0000);
      tick(1, 2);
      chk("irq1", 32'(irq1), 32'h1);
      chk("toggle1", 32'(tog1), 32'h0);
   endtask : s_ch1
   task automatic close_out;
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      s_reset();
      s_periodic();
      s_stop();
      s_toggle();
      s_debug();
      s_ch1();
      close_out();
   end
   // the whole sequence needs well under 2000 cycles
   initial begin
      #50000;
      fails++;
      close_out();
   end
endmodule : dual_channel_down_timer_tb
`default_nettype wire
